// *** tap_pkg.sv ***
// Function
// RULE1 - asserted test reset forces the controller to test-logic-reset without a tck edge
// RULE2 - in shift-ir or shift-dr the serial output changes on the falling tck edge
// RULE3 - mode select and serial input are sampled on rising tck and drive everything; the code also lets test reset force the state with no tck edge
// RULE4 - five rising edges with mode select high reach test-logic-reset from any state
// RULE5 - from test-logic-reset, mode select 0,1,1,0,0 arrives in shift-ir
// RULE6 - shift-ir places the instruction register between serial input and output
// RULE7 - in a shift state the selected register moves one bit per tck while select is low
// RULE8 - mode select high in shift-ir moves to exit1-ir and stops shifting
// RULE9 - mode select high in exit1-ir enters update-ir, where the instruction becomes active
// RULE10 - test reset input is optional; without it the five-high sequence still resets
// RULE11 - the outside controller drives tck, mode select, serial input, reset and reads output
// RULE12 - bits pass through the inserted register and then leave toward the next device
// RULE13 - the controller state alone chooses the connected register and the operation; in shift-dr the code lets the instruction pick data register or bypass
// RULE14 - all sixteen states and transitions of the standard graph are implemented
package tap_pkg;
  localparam int PIN_TCK = 0;
  localparam int PIN_TMS = 1;
  localparam int PIN_TDI = 2;
  localparam int PIN_TRST_N = 3;
  localparam int PIN_COUNT = 4;
  localparam int IR_W = 4;
  localparam int DR_W = 8;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] INSTR_BYPASS = 4'hF;
  localparam logic [IR_W-1:0] INSTR_DATA = 4'h2;
  localparam int FIFO_DEPTH = 16;
  localparam int RESET_HIGH_COUNT = 5;
  localparam int TCK_PERIOD_NS = 125;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TCK_HALF_CYCLES = (TCK_PERIOD_NS / 2) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    S_RESET, S_IDLE,
    S_SEL_DR, S_CAP_DR, S_SHIFT_DR, S_EXIT1_DR, S_PAUSE_DR, S_EXIT2_DR, S_UPD_DR,
    S_SEL_IR, S_CAP_IR, S_SHIFT_IR, S_EXIT1_IR, S_PAUSE_IR, S_EXIT2_IR, S_UPD_IR
  } tap_state_t;
endpackage

// *** tap_fifo.sv ***
`timescale 1ns/1ps
module tap_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  // head word sits in a register so the consumer sees flop outputs
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [AW:0] count_reg, count_next;
  logic out_valid_reg, out_valid_next;
  logic [WIDTH-1:0] out_data_reg, out_data_next;
  logic push, pop;

  always_comb begin
    o_in_ready = (count_reg != FULL_COUNT);
    push = i_in_valid && o_in_ready;
    pop = (count_reg != '0) && (!out_valid_reg || i_out_ready);
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    out_valid_next = out_valid_reg && !i_out_ready;
    out_data_next = out_data_reg;
    if (push) begin
      wr_ptr_next = (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
      out_valid_next = 1'b1;
      out_data_next = mem[rd_ptr_reg];
    end
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      out_valid_reg <= out_valid_next;
      out_data_reg <= out_data_next;
    end
  end

  assign o_out_valid = out_valid_reg;
  assign o_out_data = out_data_reg;
endmodule

// *** tap_controller.sv ***
`timescale 1ns/1ps
module tap_controller #(
  parameter bit HAS_TRST = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic i_trst_n,
  output logic o_tdo,
  output logic o_tdo_oe,
  output logic [tap_pkg::IR_W-1:0] o_instr,
  output logic o_test_reset,
  output logic o_update_drop,
  output logic o_dr_valid,
  output logic [tap_pkg::DR_W-1:0] o_dr_data,
  input wire logic i_dr_ready
);
  import tap_pkg::*;

  // three-stage synchronisers; a level is accepted once stages two and three agree
  logic [PIN_COUNT-1:0] s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next;
  logic tck_rise, tck_fall, tms_s, tdi_s, trst_active;

  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : lvl_reg[i];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_reg <= 4'h8;
      s2_reg <= 4'h8;
      s3_reg <= 4'h8;
      lvl_reg <= 4'h8;
    end else begin
      s1_reg <= {i_trst_n, i_tdi, i_tms, i_tck};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  // RULE3 rising-edge sampling
  assign tck_rise = lvl_next[PIN_TCK] && !lvl_reg[PIN_TCK];
  assign tck_fall = !lvl_next[PIN_TCK] && lvl_reg[PIN_TCK];
  assign tms_s = s3_reg[PIN_TMS];
  assign tdi_s = s3_reg[PIN_TDI];
  // RULE10 optional test reset
  assign trst_active = HAS_TRST && !lvl_reg[PIN_TRST_N];

  // RULE14 full transition graph
  function automatic tap_state_t step(input tap_state_t s, input logic m);
    unique case (s)
      S_RESET:    step = m ? S_RESET : S_IDLE;
      S_IDLE:     step = m ? S_SEL_DR : S_IDLE;
      S_SEL_DR:   step = m ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR:   step = m ? S_EXIT1_DR : S_SHIFT_DR;
      S_SHIFT_DR: step = m ? S_EXIT1_DR : S_SHIFT_DR;
      S_EXIT1_DR: step = m ? S_UPD_DR : S_PAUSE_DR;
      S_PAUSE_DR: step = m ? S_EXIT2_DR : S_PAUSE_DR;
      S_EXIT2_DR: step = m ? S_UPD_DR : S_SHIFT_DR;
      S_UPD_DR:   step = m ? S_SEL_DR : S_IDLE;
      S_SEL_IR:   step = m ? S_RESET : S_CAP_IR;
      S_CAP_IR:   step = m ? S_EXIT1_IR : S_SHIFT_IR;
      // RULE8 leave shift on high select
      S_SHIFT_IR: step = m ? S_EXIT1_IR : S_SHIFT_IR;
      // RULE9 exit1 to update
      S_EXIT1_IR: step = m ? S_UPD_IR : S_PAUSE_IR;
      S_PAUSE_IR: step = m ? S_EXIT2_IR : S_PAUSE_IR;
      S_EXIT2_IR: step = m ? S_UPD_IR : S_SHIFT_IR;
      S_UPD_IR:   step = m ? S_SEL_DR : S_IDLE;
    endcase
  endfunction

  tap_state_t state_reg, state_next;
  logic [IR_W-1:0] ir_shift_reg, ir_shift_next, ir_reg, ir_next;
  logic [DR_W-1:0] dr_shift_reg, dr_shift_next;
  logic byp_reg, byp_next;
  logic tdo_reg, tdo_next, oe_reg, oe_next;
  logic drop_reg, drop_next, tlr_reg;
  logic sel_data, fifo_ready, push;

  assign sel_data = (ir_reg == INSTR_DATA);

  always_comb begin
    state_next = state_reg;
    ir_shift_next = ir_shift_reg;
    ir_next = ir_reg;
    dr_shift_next = dr_shift_reg;
    byp_next = byp_reg;
    tdo_next = tdo_reg;
    oe_next = oe_reg;
    push = 1'b0;
    drop_next = 1'b0;
    // RULE1 reset needs no tck edge
    if (trst_active) begin
      state_next = S_RESET;
    end else if (tck_rise) begin
      // RULE4 five highs end in reset through the graph
      state_next = step(state_reg, tms_s);
    end
    // RULE13 state picks register and operation
    if (tck_rise) begin
      unique case (state_reg)
        S_CAP_IR: ir_shift_next = IR_CAPTURE;
        // RULE6 instruction register in path
        // RULE7 one bit per tck
        S_SHIFT_IR: ir_shift_next = {tdi_s, ir_shift_reg[IR_W-1:1]};
        // capture reports fifo room so the outside controller can throttle updates
        S_CAP_DR: begin
          dr_shift_next = {dr_shift_reg[DR_W-1:1], fifo_ready};
          byp_next = 1'b0;
        end
        S_SHIFT_DR: begin
          if (sel_data) begin
            dr_shift_next = {tdi_s, dr_shift_reg[DR_W-1:1]};
          end else begin
            byp_next = tdi_s;
          end
        end
        default: begin
        end
      endcase
    end
    if (tck_fall) begin
      // RULE2 output changes on falling tck
      // RULE12 register bits leave toward next device
      oe_next = (state_reg == S_SHIFT_IR) || (state_reg == S_SHIFT_DR);
      if (state_reg == S_SHIFT_IR) begin
        tdo_next = ir_shift_reg[0];
      end else if (state_reg == S_SHIFT_DR) begin
        tdo_next = sel_data ? dr_shift_reg[0] : byp_reg;
      end
      // RULE9 instruction becomes active
      if (state_reg == S_UPD_IR) begin
        ir_next = ir_shift_reg;
      end
      if (state_reg == S_UPD_DR && sel_data) begin
        push = fifo_ready;
        drop_next = !fifo_ready;
      end
    end
    if (state_reg == S_RESET) begin
      ir_next = INSTR_BYPASS;
      oe_next = 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= S_RESET;
      ir_shift_reg <= '0;
      ir_reg <= INSTR_BYPASS;
      dr_shift_reg <= '0;
      byp_reg <= 1'b0;
      tdo_reg <= 1'b0;
      oe_reg <= 1'b0;
      drop_reg <= 1'b0;
      tlr_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      ir_shift_reg <= ir_shift_next;
      ir_reg <= ir_next;
      dr_shift_reg <= dr_shift_next;
      byp_reg <= byp_next;
      tdo_reg <= tdo_next;
      oe_reg <= oe_next;
      drop_reg <= drop_next;
      tlr_reg <= (state_next == S_RESET);
    end
  end

  // updates that find the fifo full are dropped and flagged, tck cannot be stalled
  tap_fifo #(
    .WIDTH(DR_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in_valid(push),
    .i_in_data(dr_shift_reg),
    .o_in_ready(fifo_ready),
    .o_out_valid(o_dr_valid),
    .o_out_data(o_dr_data),
    .i_out_ready(i_dr_ready)
  );

  assign o_tdo = tdo_reg;
  assign o_tdo_oe = oe_reg;
  assign o_instr = ir_reg;
  assign o_test_reset = tlr_reg;
  assign o_update_drop = drop_reg;

  // helper: consecutive rising edges with select high
  logic [2:0] high_cnt_reg, high_cnt_next;
  always_comb begin
    high_cnt_next = high_cnt_reg;
    if (trst_active) begin
      high_cnt_next = 3'h0;
    end else if (tck_rise) begin
      if (!tms_s) begin
        high_cnt_next = 3'h0;
      end else if (high_cnt_reg != 3'(RESET_HIGH_COUNT)) begin
        high_cnt_next = high_cnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      high_cnt_reg <= '0;
    end else begin
      high_cnt_reg <= high_cnt_next;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_trst_forces_reset: assert property (trst_active |=> state_reg == S_RESET) // RULE1
    else $error("test reset did not force reset state");
  a_trst_oe_off: assert property (trst_active |-> ##2 !o_tdo_oe) // RULE1
    else $error("test reset did not release the serial output");
  // a forced reset may drop the drive enable between falling edges
  a_tdo_on_fall: assert property ( // RULE2
    !tck_fall && state_reg != S_RESET |=> $stable(o_tdo) && $stable(o_tdo_oe)
  )
    else $error("serial output moved outside a falling tck edge");
  a_state_on_rise: assert property (!tck_rise && !trst_active |=> $stable(state_reg)) // RULE3
    else $error("state changed without a rising tck edge");
  a_five_high_reset: assert property ( // RULE4
    high_cnt_reg == 3'(RESET_HIGH_COUNT) |-> state_reg == S_RESET
  )
    else $error("five high selects did not reach reset");
  a_sel_ir_reset: assert property ( // RULE4
    tck_rise && !trst_active && state_reg == S_SEL_IR && tms_s |=> state_reg == S_RESET
  )
    else $error("select-ir did not fall back to reset on high select");
  a_reset_to_idle: assert property ( // RULE5
    tck_rise && !trst_active && state_reg == S_RESET && !tms_s |=> state_reg == S_IDLE
  )
    else $error("reset did not move to idle on low select");
  a_capture_to_shift: assert property ( // RULE5
    tck_rise && !trst_active && state_reg == S_CAP_IR && !tms_s |=> state_reg == S_SHIFT_IR
  )
    else $error("capture-ir did not enter shift-ir");
  a_cap_ir_load: assert property ( // RULE6
    tck_rise && state_reg == S_CAP_IR |=> ir_shift_reg == IR_CAPTURE
  )
    else $error("capture-ir did not load the capture pattern");
  a_ir_shift_step: assert property ( // RULE7
    tck_rise && !trst_active && state_reg == S_SHIFT_IR
    |=> ir_shift_reg == {$past(tdi_s), $past(ir_shift_reg[IR_W-1:1])}
  )
    else $error("instruction register did not shift by one");
  a_dr_shift_step: assert property ( // RULE7
    tck_rise && !trst_active && state_reg == S_SHIFT_DR && sel_data
    |=> dr_shift_reg == {$past(tdi_s), $past(dr_shift_reg[DR_W-1:1])}
  )
    else $error("data register did not shift by one");
  a_shift_exit: assert property ( // RULE8
    tck_rise && !trst_active && state_reg == S_SHIFT_IR && tms_s
    |=> state_reg == S_EXIT1_IR ##1 $stable(ir_shift_reg)
  )
    else $error("shift-ir did not exit on high select");
  a_update_ir_load: assert property ( // RULE9
    tck_fall && state_reg == S_UPD_IR |=> o_instr == $past(ir_shift_reg)
  )
    else $error("update-ir did not load the instruction");
  a_instr_hold: assert property ( // RULE9
    !(tck_fall && state_reg == S_UPD_IR) && state_reg != S_RESET |=> $stable(o_instr)
  )
    else $error("instruction changed outside update-ir");
  a_ir_out_path: assert property ( // RULE12
    tck_fall && state_reg == S_SHIFT_IR |=> o_tdo == $past(ir_shift_reg[0]) && o_tdo_oe
  )
    else $error("instruction bit not driven out");
  a_dr_out_path: assert property ( // RULE12
    tck_fall && state_reg == S_SHIFT_DR && sel_data
    |=> o_tdo == $past(dr_shift_reg[0]) && o_tdo_oe
  )
    else $error("data register bit not driven out");
  a_bypass_step: assert property ( // RULE12
    tck_rise && !trst_active && state_reg == S_SHIFT_DR && !sel_data
    |=> byp_reg == $past(tdi_s)
  )
    else $error("bypass bit did not take the serial input");
  a_full_drop: assert property ( // RULE12
    tck_fall && state_reg == S_UPD_DR && sel_data && !fifo_ready |=> o_update_drop
  )
    else $error("update into a full fifo was not flagged");
  a_oe_by_state: assert property ( // RULE13
    tck_fall && state_reg != S_SHIFT_IR && state_reg != S_SHIFT_DR |=> !o_tdo_oe
  )
    else $error("output enabled outside a shift state");
  a_reset_instr: assert property (state_reg == S_RESET |=> o_instr == INSTR_BYPASS) // RULE13
    else $error("reset state did not select bypass");
  a_pause_exit2: assert property ( // RULE14
    tck_rise && !trst_active && state_reg == S_PAUSE_DR && tms_s |=> state_reg == S_EXIT2_DR
  )
    else $error("pause-dr did not move to exit2-dr");

  c_shift_ir: cover property (state_reg == S_CAP_IR ##[1:40] state_reg == S_SHIFT_IR);
  c_fifo_push: cover property (push ##[1:20] o_dr_valid);
  c_update_drop: cover property (o_update_drop);
  c_five_high: cover property (high_cnt_reg == 3'(RESET_HIGH_COUNT));
  c_pause_dr: cover property (state_reg == S_PAUSE_DR ##[1:40] state_reg == S_EXIT2_DR);
endmodule

// *** tap_host_model.sv ***
`timescale 1ns/1ps
module tap_host_model (
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  output logic o_trst_n,
  input wire logic i_tdo
);
  // host sources tck and the control lines
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b0;
    o_tdi = 1'b0;
    o_trst_n = 1'b1;
  end
  // tms and tdi settle half a period before the rise, tdo read at the rise
  task automatic pulse(input logic tms, input logic tdi, output logic tdo, output logic late);
    o_tms = tms;
    o_tdi = tdi;
    #62.5 o_tck = 1'b1;
    tdo = i_tdo;
    #62 late = i_tdo;
    #0.5 o_tck = 1'b0;
  endtask
  // idle data line toggles so a stale bit is never taken for data
  task automatic move(input logic tms);
    logic a;
    logic b;
    pulse(tms, ~o_tdi, a, b);
  endtask
  task automatic reset_by_tms();
    repeat (5) move(1'b1);
  endtask
  task automatic set_trst(input logic v);
    o_trst_n = v;
  endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  import tap_pkg::*;
  localparam int CAP = FIFO_DEPTH + 1;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe, tdo_line, test_reset, update_drop, dr_valid;
  logic dr_ready;
  logic drain_on = 1'b0;
  logic [IR_W-1:0] instr;
  logic [DR_W-1:0] dr_data;
  int errors = 0;
  int checks_done = 0;
  int drops_seen = 0;
  int drops_exp = 0;
  logic [7:0] q[$];
  always #5 i_clk = ~i_clk;
  // released tdo shows the inverse so an undriven bit cannot match
  assign tdo_line = tdo_oe ? tdo : ~tdo;
  tap_host_model host_u (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n),
    .i_tdo(tdo_line));
  tap_controller dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_tck(tck),
    .i_tms(tms), .i_tdi(tdi), .i_trst_n(trst_n), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
    .o_instr(instr), .o_test_reset(test_reset), .o_update_drop(update_drop),
    .o_dr_valid(dr_valid), .o_dr_data(dr_data), .i_dr_ready(dr_ready));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic walk(input logic [7:0] seq, input int n);
    for (int i = n - 1; i >= 0; i--)
      host_u.move(seq[i]);
  endtask
  task automatic shift(input logic [7:0] din, input int n, output logic [7:0] dout);
    logic b;
    logic late;
    dout = 8'h00;
    for (int i = 0; i < n; i++) begin
      host_u.pulse(i == n - 1, din[i], b, late);
      dout[i] = b;
      check("tdo_hold", late, b);
    end
    walk(8'b10, 2);
  endtask
  task automatic ir_load(input logic [IR_W-1:0] v);
    logic [7:0] d;
    walk(8'b1100, 4);
    shift(8'(v), IR_W, d);
    check("ir_capture", d, 8'(IR_CAPTURE));
    repeat (8) @(posedge i_clk);
    check("instr", 8'(instr), 8'(v));
    check("oe_after_shift", tdo_oe, 1'b0);
  endtask

  always @(posedge i_clk) begin
    if (drain_on)
      dr_ready <= 1'($urandom_range(1));
    else
      dr_ready <= 1'b0;
  end
  always @(negedge i_clk) begin
    if (update_drop === 1'b1)
      drops_seen++;
    if (dr_valid === 1'b1 && dr_ready === 1'b1) begin
      if (q.size() == 0)
        check("pop_empty", 8'h01, 8'h00);
      else
        check("fifo_word", dr_data, q.pop_front());
    end
  end
  initial begin
    #1_000_000;
    errors++;
    wrap_up();
  end

  initial begin
    logic [7:0] w;
    logic [7:0] d;
    void'($urandom(41));
    repeat (6) @(posedge i_clk);
    check("reset_state", test_reset, 1'b1);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    // one idle step plus 1100 gives 01100 from reset
    host_u.move(1'b0);
    ir_load(INSTR_DATA);
    $display("test ir_load done");
    for (int k = 0; k < CAP + 2; k++) begin
      w = 8'($urandom);
      walk(8'b100, 3);
      shift(w, DR_W, d);
      check("room_bit", d[0], q.size() < CAP);
      if (q.size() < CAP)
        q.push_back(w);
      else
        drops_exp++;
    end
    repeat (8) @(posedge i_clk);
    check("drops", 8'(drops_seen), 8'(drops_exp));
    drain_on <= 1'b1;
    for (int i = 0; i < 1000 && q.size() > 0; i++)
      @(posedge i_clk);
    if (q.size() > 0) begin
      errors++;
      wrap_up();
    end
    repeat (4) @(posedge i_clk);
    check("drained", dr_valid, 1'b0);
    $display("test fifo done");
    walk(8'b100, 3);
    host_u.set_trst(1'b0);
    repeat (8) @(posedge i_clk);
    check("trst_state", test_reset, 1'b1);
    check("trst_instr", 8'(instr), 8'(INSTR_BYPASS));
    host_u.set_trst(1'b1);
    repeat (4) @(posedge i_clk);
    $display("test trst done");
    host_u.move(1'b0);
    walk(8'($urandom), 8);
    host_u.reset_by_tms();
    repeat (6) @(posedge i_clk);
    check("five_high", test_reset, 1'b1);
    $display("test five_high done");
    host_u.move(1'b0);
    w = 8'($urandom);
    walk(8'b100, 3);
    shift(w, DR_W, d);
    check("bypass", d, {w[6:0], 1'b0});
    $display("test bypass done");
    // select-dr, capture, exit1, two pauses, exit2, update, idle
    walk(8'hA6, 8);
    repeat (6) @(posedge i_clk);
    check("pause_path", 8'({test_reset, tdo_oe}), 8'h00);
    check("pause_instr", 8'(instr), 8'(INSTR_BYPASS));
    $display("test pause done");
    wrap_up();
  end
endmodule
